// ---- ssp_pkg.sv ----
package ssp_pkg;

   // raw serial pins as they arrive from the host
   typedef struct packed {
      logic enable_n;
      logic sclk;
      logic sdata;
   } ssp_pins_t;

   typedef enum logic [1:0] {
      SSP_SEL_PORT,
      SSP_SEL_DOUT,
      SSP_SEL_VCO,
      SSP_SEL_REF
   } ssp_sel_t;

   localparam int SSP_SYNC_STAGES = 3;
   localparam int SSP_PIN_EN = 2;
   localparam int SSP_PIN_SCLK = 1;
   localparam int SSP_PIN_DATA = 0;

   localparam int SSP_CFG_W = 8;
   localparam int SSP_REF_W = 16;
   localparam int SSP_LOOP_W = 24;
   localparam int SSP_REF_DIV_W = 13;
   localparam int SSP_REF_TOP_W = 3;
   localparam int SSP_N_W = 12;
   localparam int SSP_A_W = 6;
   localparam int SSP_TOTAL_W = 18;

   localparam logic [5:0] SSP_LEN_NONE = 6'h00;
   localparam logic [5:0] SSP_LEN_CFG = 6'h08;
   localparam logic [5:0] SSP_LEN_REF = 6'h10;
   localparam logic [5:0] SSP_LEN_LOOP = 6'h18;
   localparam logic [5:0] SSP_LEN_MAX = 6'h20;

   localparam int SSP_CFG_PORT_BIT = 1;
   localparam int SSP_CFG_OD_BIT = 0;
   localparam int SSP_LOOP_SEL_HI = 23;
   localparam int SSP_LOOP_SEL_LO = 22;
   localparam int SSP_LOOP_N_LSB = 6;
   localparam int SSP_LOOP_N_MSB = 17;
   localparam int SSP_LOOP_A_MSB = 5;

   localparam logic [7:0] SSP_CFG_RST = 8'h00;
   localparam logic [12:0] SSP_REF_DIV_RST = 13'h0000;
   localparam logic [2:0] SSP_REF_TOP_RST = 3'h0;
   localparam logic [23:0] SSP_LOOP_RST = 24'h400000;

endpackage

// ---- ssp_synth_port.sv ----
`timescale 1ns/1ps
// Overview of operation
// - frames arrive msb first; data sampled on each serial clock rising edge.
// - 8 clocks load config, 16 load first reference buffer, 24 load loop word.
// - config, reference and loop registers hold steady while bits shift.
// - enable rising edge copies the shift register into the target register.
// - low 13 reference bits double-buffered; top 3 act right after 16-clock transfer.
// - loop word transfer also moves first reference buffer into the second.
// - enable low pulse without clocks also moves first reference buffer to second.
// - no address bits; registers may be written in any order.
// - static 24-and-a-half stage shift register tolerates any slow clock.
// - cascade data out changes on serial clock falling edge.
// - enable high blocks shifting and holds the port initialised.
// - enable edge while clock high desyncs; resync when enable high, clock low.
// - power-up needs clock low or enable high; reset here initialises all.
// - two loop bits select reference, vco, cascade data or port level.
// - 13-stage reference divider, 5 to 8191 or 1 bypass, pulses high.
// - vco pulse after main value times 64 plus swallow input events.
// - after reset the multiplexed output carries cascade data out.
// - port mode drives the multiplexed output to config bit 1.
// - open-drain output pulls low when config bit 0 low, floats when high.
// - reset forces the open-drain output low.
module ssp_synth_port (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire ssp_pkg::ssp_pins_t pins,
   input wire logic ref_tick,
   input wire logic rf_tick,
   output logic [7:0] config_byte,
   output logic [2:0] ref_top_bits,
   output logic [12:0] ref_divide_value,
   output logic [23:0] loop_word,
   output logic reference_pulse,
   output logic vco_pulse,
   output logic mux_out,
   output logic outb_o,
   output logic outb_oe
);
   import ssp_pkg::*;

   typedef enum logic [1:0] {
      PS_IDLE,
      PS_SHIFT,
      PS_DESYNC
   } ssp_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: a change counts once stages two and three agree

   logic [2:0] raw;
   logic [2:0] s1_q, s2_q, s3_q;
   logic [2:0] filt_d, filt_q, prev_q;

   assign raw = pins;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         // idle levels: enable high, clock low
         s1_q <= 3'h4;
         s2_q <= 3'h4;
         s3_q <= 3'h4;
         filt_q <= 3'h4;
         prev_q <= 3'h4;
      end else if (clk_en) begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
      end
   end

   logic en_lvl, sclk_lvl, sdata_lvl;
   logic sclk_rise, sclk_fall, en_fall, en_rise;

   assign en_lvl = filt_q[SSP_PIN_EN];
   assign sclk_lvl = filt_q[SSP_PIN_SCLK];
   assign sdata_lvl = filt_q[SSP_PIN_DATA];
   assign sclk_rise = sclk_lvl & ~prev_q[SSP_PIN_SCLK];
   assign sclk_fall = ~sclk_lvl & prev_q[SSP_PIN_SCLK];
   assign en_fall = ~en_lvl & prev_q[SSP_PIN_EN];
   assign en_rise = en_lvl & ~prev_q[SSP_PIN_EN];

   ////////////////////////////////////////////////////////////////////////////
   // serial port: shift register, frame counter and transfers

   ssp_state_t state_d, state_q;
   logic [23:0] sr_d, sr_q;
   logic half_d, half_q;
   logic [5:0] count_d, count_q;
   logic [7:0] cfg_d, cfg_q;
   logic [12:0] ref1_d, ref1_q, ref2_d, ref2_q;
   logic [2:0] top_d, top_q;
   logic [23:0] loop_d, loop_q;

   always_comb begin
      state_d = state_q;
      sr_d = sr_q;
      half_d = half_q;
      count_d = count_q;
      cfg_d = cfg_q;
      ref1_d = ref1_q;
      ref2_d = ref2_q;
      top_d = top_q;
      loop_d = loop_q;
      case (state_q)
         PS_IDLE: begin
            count_d = SSP_LEN_NONE;
            if (en_fall) begin
               state_d = sclk_lvl ? PS_DESYNC : PS_SHIFT;
            end
         end
         PS_SHIFT: begin
            if (en_rise) begin
               if (sclk_lvl) begin
                  // enable moved with clock high: drop the frame
                  state_d = PS_DESYNC;
               end else begin
                  state_d = PS_IDLE;
                  // length alone picks the target, no address bits
                  if (count_q == SSP_LEN_CFG) begin
                     cfg_d = sr_q[SSP_CFG_W-1:0];
                  end else if (count_q == SSP_LEN_REF) begin
                     ref1_d = sr_q[SSP_REF_DIV_W-1:0];
                     top_d = sr_q[SSP_REF_W-1:SSP_REF_DIV_W];
                  end else if (count_q == SSP_LEN_LOOP) begin
                     loop_d = sr_q;
                     ref2_d = ref1_q;
                  end else if (count_q == SSP_LEN_NONE) begin
                     ref2_d = ref1_q;
                  end
                  // other lengths are not allowed and change nothing
               end
            end else begin
               if (sclk_rise && count_q != SSP_LEN_MAX) begin
                  // static storage: any gap between edges is fine
                  sr_d = {sr_q[22:0], sdata_lvl};
                  count_d = count_q + 6'h01;
               end
               if (sclk_fall) begin
                  half_d = sr_q[23];
               end
            end
         end
         PS_DESYNC: begin
            if (en_lvl && !sclk_lvl) begin
               state_d = PS_IDLE;
            end
         end
         default: begin
            state_d = PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         // power-on state; pins must idle sanely for this to mean anything
         state_q <= PS_IDLE;
         sr_q <= 24'h000000;
         half_q <= 1'b0;
         count_q <= SSP_LEN_NONE;
         cfg_q <= SSP_CFG_RST;
         ref1_q <= SSP_REF_DIV_RST;
         ref2_q <= SSP_REF_DIV_RST;
         top_q <= SSP_REF_TOP_RST;
         loop_q <= SSP_LOOP_RST;
      end else if (clk_en) begin
         state_q <= state_d;
         sr_q <= sr_d;
         half_q <= half_d;
         count_q <= count_d;
         cfg_q <= cfg_d;
         ref1_q <= ref1_d;
         ref2_q <= ref2_d;
         top_q <= top_d;
         loop_q <= loop_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dividers and output multiplexer

   logic [12:0] rcnt_d, rcnt_q;
   logic [17:0] vcnt_d, vcnt_q;
   logic [17:0] total;
   logic rpulse_d, rpulse_q, vpulse_d, vpulse_q, mux_d, mux_q;
   ssp_sel_t sel;

   // main value must be at least the swallow value; not checked here
   assign total = SSP_TOTAL_W'({loop_q[SSP_LOOP_N_MSB:SSP_LOOP_N_LSB], 6'h00})
                  + SSP_TOTAL_W'(loop_q[SSP_LOOP_A_MSB:0]);
   assign sel = ssp_sel_t'({loop_q[SSP_LOOP_SEL_HI], loop_q[SSP_LOOP_SEL_LO]});

   always_comb begin
      rcnt_d = rcnt_q;
      vcnt_d = vcnt_q;
      rpulse_d = 1'b0;
      vpulse_d = 1'b0;
      if (ref_tick) begin
         // values 0 and 1 both bypass; 2 to 4 are outside the rated range
         if (ref2_q <= 13'h0001 || rcnt_q >= ref2_q - 13'h0001) begin
            rcnt_d = 13'h0000;
            rpulse_d = 1'b1;
         end else begin
            rcnt_d = rcnt_q + 13'h0001;
         end
      end
      if (rf_tick) begin
         if (total <= 18'h00001 || vcnt_q >= total - 18'h00001) begin
            vcnt_d = 18'h00000;
            vpulse_d = 1'b1;
         end else begin
            vcnt_d = vcnt_q + 18'h00001;
         end
      end
      case (sel)
         SSP_SEL_REF: mux_d = rpulse_d;
         SSP_SEL_VCO: mux_d = vpulse_d;
         SSP_SEL_DOUT: mux_d = half_d;
         default: mux_d = cfg_q[SSP_CFG_PORT_BIT];
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rcnt_q <= 13'h0000;
         vcnt_q <= 18'h00000;
         rpulse_q <= 1'b0;
         vpulse_q <= 1'b0;
         mux_q <= 1'b0;
      end else if (clk_en) begin
         rcnt_q <= rcnt_d;
         vcnt_q <= vcnt_d;
         rpulse_q <= rpulse_d;
         vpulse_q <= vpulse_d;
         mux_q <= mux_d;
      end
   end

   assign config_byte = cfg_q;
   assign ref_top_bits = top_q;
   assign ref_divide_value = ref2_q;
   assign loop_word = loop_q;
   assign reference_pulse = rpulse_q;
   assign vco_pulse = vpulse_q;
   assign mux_out = mux_q;
   assign outb_o = 1'b0;
   assign outb_oe = ~cfg_q[SSP_CFG_OD_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic xfer;
   assign xfer = clk_en && state_q == PS_SHIFT && en_rise && !sclk_lvl;

   shift_msb_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == PS_SHIFT && !en_rise && sclk_rise && count_q != SSP_LEN_MAX
      |=> sr_q == {$past(sr_q[22:0]), $past(sdata_lvl)} && count_q == $past(count_q) + 6'h01)
      else $error("shift register did not take the sampled bit");

   cfg_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_CFG |=> cfg_q == $past(sr_q[7:0]) && $stable(loop_q))
      else $error("8-clock frame did not load the config byte");

   ref_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_REF
      |=> ref1_q == $past(sr_q[12:0]) && top_q == $past(sr_q[15:13]) && $stable(ref2_q))
      else $error("16-clock frame loaded the wrong buffer");

   loop_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_LOOP |=> loop_q == $past(sr_q) && ref2_q == $past(ref1_q))
      else $error("24-clock frame did not load loop word and second buffer");

   pulse_copy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_NONE |=> ref2_q == $past(ref1_q) && $stable(cfg_q))
      else $error("clockless enable pulse did not copy the reference buffer");

   regs_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !xfer |=> $stable(cfg_q) && $stable(loop_q) && $stable(ref1_q) && $stable(ref2_q))
      else $error("register changed outside an enable transfer");

   idle_init_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == PS_IDLE |=> count_q == SSP_LEN_NONE)
      else $error("port not held initialised while enable high");

   desync_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == PS_SHIFT && en_rise && sclk_lvl
      |=> state_q == PS_DESYNC && $stable(cfg_q) && $stable(loop_q))
      else $error("enable edge with clock high was not rejected");

   port_mode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && sel == SSP_SEL_PORT |=> mux_out == $past(cfg_q[1]))
      else $error("port mode output does not follow config bit 1");

   dout_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && sel == SSP_SEL_DOUT && state_q == PS_SHIFT && !en_rise && sclk_fall
      |=> mux_out == $past(sr_q[23]))
      else $error("cascade data did not change on clock fall");

   reset_init_a: assert property (@(posedge core_clk)
      !reset_n |=> outb_oe && sel == SSP_SEL_DOUT && !mux_out)
      else $error("reset did not select data out and pull output b low");

   ref_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && !ref_tick |=> !reference_pulse)
      else $error("reference pulse without an input event");

   vco_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && !rf_tick |=> !vco_pulse)
      else $error("vco pulse without an input event");

   desync_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == PS_DESYNC |=> $stable(sr_q) && $stable(half_q) && $stable(count_q))
      else $error("shift register moved while out of sync");

   idle_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && state_q == PS_IDLE |=> $stable(sr_q) && $stable(half_q))
      else $error("shift register moved while enable high");

   // a stopped enable must look like a stopped clock to every register
   freeze_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !clk_en |=> $stable(state_q) && $stable(sr_q) && $stable(count_q) && $stable(filt_q)
         && $stable(cfg_q) && $stable(rcnt_q) && $stable(mux_q))
      else $error("state moved while the clock enable was low");

   cfg_write_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_CFG);
   loop_write_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_LOOP);
   bare_pulse_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      xfer && count_q == SSP_LEN_NONE);
   desync_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      state_q == PS_DESYNC ##1 state_q == PS_IDLE);
   dout_shift_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      clk_en && sel == SSP_SEL_DOUT && sclk_fall && state_q == PS_SHIFT);

endmodule

// ---- ssp_host_model.sv ----
`timescale 1ns/1ps
module ssp_host_model (
   input wire logic core_clk,
   output ssp_pkg::ssp_pins_t pins
);
   import ssp_pkg::*;

   // idle with enable high and clock low so the port starts in sync
   initial pins = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   // each level is held several core cycles so the pin filter sees it
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // only 0, 8, 16 or 24 clocks are ever sent; half sets slow or fast frames
   task automatic send(input int nbits, input logic [23:0] word, input int half);
      pins.enable_n = 1'b0;
      hold(half);
      for (int i = nbits - 1; i >= 0; i--) begin
         pins.sdata = word[i];
         hold(half);
         pins.sclk = 1'b1;
         hold(half);
         pins.sclk = 1'b0;
      end
      hold(half);
      pins.enable_n = 1'b1;
      // data line no longer meaningful, so it does not keep the last bit
      pins.sdata = ~pins.sdata;
      hold(8);
   endtask

   // one bit, then enable raised with the clock still high: frame must be dropped
   task automatic desync(input logic bit_val);
      pins.enable_n = 1'b0;
      hold(6);
      pins.sdata = bit_val;
      hold(6);
      pins.sclk = 1'b1;
      hold(6);
      pins.enable_n = 1'b1;
      hold(6);
      pins.sclk = 1'b0;
      hold(8);
   endtask
endmodule

// ---- synth_serial_port_outputs_test.sv ----
`timescale 1ns/1ps
module synth_serial_port_outputs_test;
   import ssp_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic ref_tick = 1'b0;
   logic rf_tick = 1'b0;
   ssp_pins_t pins;
   logic [7:0] config_byte;
   logic [2:0] ref_top_bits;
   logic [12:0] ref_divide_value;
   logic [23:0] loop_word;
   logic reference_pulse;
   logic vco_pulse;
   logic mux_out;
   logic outb_o;
   logic outb_oe;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h000046fd;
   int m_cfg = 0;
   int m_ref1 = 0;
   int m_ref2 = 0;
   int m_top = 0;
   int m_loop = 32'h00400000;
   int m_sr = 0;
   int m_half = 0;
   int r;

   ssp_host_model host_u (.core_clk(core_clk), .pins(pins));

   ssp_synth_port dut_u (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .pins(pins),
      .ref_tick(ref_tick),
      .rf_tick(rf_tick),
      .config_byte(config_byte),
      .ref_top_bits(ref_top_bits),
      .ref_divide_value(ref_divide_value),
      .loop_word(loop_word),
      .reference_pulse(reference_pulse),
      .vco_pulse(vco_pulse),
      .mux_out(mux_out),
      .outb_o(outb_o),
      .outb_oe(outb_oe)
   );

   always #2 core_clk = ~core_clk;

   // generous ceiling: 24-clock loop frames dominate the run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [23:0] val, input int exp, input string what);
      checks_done++;
      if (val !== exp[23:0]) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, val, exp[23:0]);
      end
   endtask

   task automatic compare_all();
      check(config_byte, m_cfg, "config");
      check(ref_top_bits, m_top, "top bits");
      check(ref_divide_value, m_ref2, "divide");
      check(loop_word, m_loop, "loop");
      check(outb_oe, ~m_cfg & 1, "drain enable");
      check(outb_o, 0, "drain data");
      if (m_loop[23:22] == 2'b00) begin
         check(mux_out, (m_cfg >> 1) & 1, "port");
      end
   endtask

   // data out only settles after a whole frame, so it is not part of compare_all
   task automatic check_dout();
      if (m_loop[23:22] == 2'b01) begin
         check(mux_out, m_half, "data out");
      end
   endtask

   // registers are compared mid-frame too, before the enable rise
   task automatic write(input int n, input int w, input int half);
      fork
         host_u.send(n, w[23:0], half);
         begin
            repeat (n * 2 * half) @(posedge core_clk);
            #1;
            compare_all();
         end
      join
      case (n)
         8: m_cfg = w & 32'h000000ff;
         16: begin
            m_ref1 = w & 32'h00001fff;
            m_top = (w >> 13) & 32'h00000007;
         end
         24: begin
            m_loop = w & 32'h00ffffff;
            m_ref2 = m_ref1;
         end
         default: m_ref2 = m_ref1;
      endcase
      if (n > 0) begin
         m_sr = ((m_sr << n) | (w & ((1 << n) - 1))) & 32'h00ffffff;
         m_half = (m_sr >> 23) & 1;
      end
      compare_all();
      check_dout();
   endtask

   // ticks every other cycle; period is ticks between two pulses
   task automatic measure(input logic use_rf, input int exp, input logic on_mux);
      int n;
      int hits;
      int mux_hits;
      n = 0;
      hits = 0;
      mux_hits = 0;
      while (hits < 2 && n < 600) begin
         ref_tick = ~use_rf;
         rf_tick = use_rf;
         @(posedge core_clk);
         #1;
         ref_tick = 1'b0;
         rf_tick = 1'b0;
         n++;
         if ((use_rf ? vco_pulse : reference_pulse) === 1'b1) begin
            hits++;
            if (hits == 1) begin
               n = 0;
            end
         end
         // mux register loads from the same next value as the pulse flop
         if (mux_out === 1'b1) begin
            mux_hits++;
         end
         @(posedge core_clk);
         #1;
      end
      check(n, exp, "period");
      check(mux_hits, on_mux ? 2 : 0, "mux pulses");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      compare_all();
      for (int k = 0; k < 12; k++) begin
         r = rnd();
         case (r[1:0])
            2'd0: write(8, r >> 8, 6);
            2'd1: write(16, r >> 8, r[2] ? 30 : 6);
            2'd2: write(0, 0, 6);
            default: write(24, {r[9:8], 4'h0, 6'h01, r[15:10], r[21:16]}, 6);
         endcase
      end
      write(24, 24'h000081, 6);
      write(8, 32'h00000002, 6);
      write(8, 32'h00000001, 6);
      write(24, 24'h400081, 6);
      host_u.desync(1'b1);
      m_sr = ((m_sr << 1) | 1) & 32'h00ffffff;
      compare_all();
      check_dout();
      write(16, 5, 6);
      write(24, 24'hc00042, 6);
      measure(1'b0, m_ref2, 1'b1);
      write(16, 1, 6);
      write(0, 0, 6);
      // bypass divide would pulse on every tick unless the enable freezes it
      clk_en = 1'b0;
      ref_tick = 1'b1;
      repeat (10) begin
         @(posedge core_clk);
         #1;
         check(reference_pulse, 0, "frozen pulse");
      end
      ref_tick = 1'b0;
      clk_en = 1'b1;
      measure(1'b0, 1, 1'b1);
      write(24, 24'h800042, 6);
      measure(1'b1, ((m_loop >> 6) & 32'h00000fff) * 64 + (m_loop & 32'h0000003f), 1'b1);
      measure(1'b0, 1, 1'b0);
      complete_run();
   end
endmodule
